// [src/cfgx_pkg.sv]
/*
 Constants shared by the configuration extension port: register-number
 windows owned by user logic, field widths, clock rates and lane masks.
 Assumes a single 100 MHz clock for all design logic.
*/
package cfgx_pkg;
   // ------------------------------------------------------------
   // field widths
   // ------------------------------------------------------------
   localparam int REG_W  = 10;
   localparam int FUNC_W = 8;
   localparam int DATA_W = 32;
   localparam int BE_W   = 4;
   localparam int LANE_W = 8;

   // ------------------------------------------------------------
   // user-owned register-number windows
   // ------------------------------------------------------------
   localparam logic [REG_W-1:0] LEGACY_LO = 10'h010;
   localparam logic [REG_W-1:0] LEGACY_HI = 10'h01f;
   localparam logic [REG_W-1:0] EXT_LO    = 10'h100;
   localparam logic [REG_W-1:0] EXT_HI    = 10'h3ff;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [REG_W-1:0]  REG_RST  = 10'h000;
   localparam logic [FUNC_W-1:0] FUNC_RST = 8'h00;
   localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
   localparam logic [BE_W-1:0]   BE_RST   = 4'h0;
   localparam logic [LANE_W-1:0] LANE_RST = 8'h00;

   // ------------------------------------------------------------
   // timing: system clock and selectable user clock rates, in kHz
   // ------------------------------------------------------------
   localparam int CLK_KHZ      = 100000;
   localparam int UCLK_62_KHZ  = 62500;
   localparam int UCLK_125_KHZ = 125000;
   localparam int UCLK_250_KHZ = 250000;
   localparam int RST_SYNC_N   = 3;

   // ------------------------------------------------------------
   // link-width lane masks
   // ------------------------------------------------------------
   localparam logic [LANE_W-1:0] LANES_X1 = 8'h01;
   localparam logic [LANE_W-1:0] LANES_X2 = 8'h03;
   localparam logic [LANE_W-1:0] LANES_X4 = 8'h0f;
   localparam logic [LANE_W-1:0] LANES_X8 = 8'hff;

   typedef enum logic [1:0] {UCLK_62, UCLK_125, UCLK_250} cfgx_uclk_e;
   typedef enum logic [1:0] {WIDTH_X1, WIDTH_X2, WIDTH_X4, WIDTH_X8} cfgx_width_e;
   typedef enum {ST_IDLE, ST_HOLD} cfgx_state_e;
endpackage

// [src/cfgx_reset_bridge.sv]
/*
 Reset bridge for the user-side reset output.
 Assumes sys_reset is an asynchronous active-high pin; nrst is a
 synchronous active-low reset on clock.
*/
`timescale 1ns/1ns
module cfgx_reset_bridge (
   input  wire logic clock,
   input  wire logic nrst,
   input  wire logic sys_reset,
   output logic      user_reset
);
   typedef struct packed {
      logic [cfgx_pkg::RST_SYNC_N-1:0] chain;
      logic                            held;
   } cfgx_rb_s;

   cfgx_rb_s st;
   cfgx_rb_s next_st;

   // ------------------------------------------------------------
   // release shifts through three flops, assertion is immediate
   // ------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      next_st.chain = {st.chain[cfgx_pkg::RST_SYNC_N-2:0], 1'b0};
      if (!nrst)
      begin
         next_st.chain = '1;
      end
      // registered copy: low only when second and third stages agree low
      next_st.held = next_st.chain[cfgx_pkg::RST_SYNC_N-1]
                   | next_st.chain[cfgx_pkg::RST_SYNC_N-2];
   end

   always_ff @(posedge clock or posedge sys_reset)
   begin
      if (sys_reset)
      begin
         st <= '1;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign user_reset = st.held;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_reset_async_set: assert property (@(posedge clock) disable iff (!nrst)
      sys_reset |-> user_reset) else $error("user reset low during sys reset");
   a_reset_release_sync: assert property (@(posedge clock) disable iff (!nrst)
      $past(sys_reset) && !sys_reset |-> user_reset ##1 user_reset)
      else $error("user reset released too early");
endmodule

// [src/cfgx_port.sv]
/*
 Configuration extension port: forwards configuration reads and writes
 from the link-side request port to user logic, holds reads of
 user-owned registers until user data returns, and answers reads on the
 completion port. Also drives user reset, user clock tick and lane mask.
 Assumes the link side holds a request until req_ready is seen high and
 that user logic runs on the same clock.
*/
// Function
// - with no user spaces enabled, reads give a one-cycle read indication
// - reads in enabled user windows hold the indication until user data valid
// - reads outside user windows always give a one-cycle indication
// - every configuration write gives a one-cycle write indication
// - 10-bit register number valid while either indication is high
// - 8-bit function number valid while either indication is high
// - 32-bit write data valid while write indication is high
// - 4-bit byte enables accompany each write
// - user read data captured on the edge after indication, if valid set
// - user reset releases synchronously to the system clock
// - user reset asserts at once on system reset
// - system reset is active-high, asynchronous, fundamental
// - user clock has one fixed rate chosen at build time
// - only lanes of the configured link width are used
`timescale 1ns/1ns
module cfgx_port #(
   parameter cfgx_pkg::cfgx_uclk_e  UCLK_SEL   = cfgx_pkg::UCLK_125,
   parameter cfgx_pkg::cfgx_width_e LINK_WIDTH = cfgx_pkg::WIDTH_X8
) (
   input  wire logic                        clock,
   input  wire logic                        nrst,
   input  wire logic                        sys_reset,
   input  wire logic                        legacy_user_en,
   input  wire logic                        ext_user_en,
   input  wire logic                        req_valid,
   input  wire logic                        req_is_write,
   input  wire logic [cfgx_pkg::REG_W-1:0]  req_reg_num,
   input  wire logic [cfgx_pkg::FUNC_W-1:0] req_func_num,
   input  wire logic [cfgx_pkg::DATA_W-1:0] req_write_data,
   input  wire logic [cfgx_pkg::BE_W-1:0]   req_byte_enable,
   output logic                             req_ready,
   output logic                             read_received,
   output logic                             write_received,
   output logic [cfgx_pkg::REG_W-1:0]       register_number,
   output logic [cfgx_pkg::FUNC_W-1:0]      function_number,
   output logic [cfgx_pkg::DATA_W-1:0]      write_data,
   output logic [cfgx_pkg::BE_W-1:0]        write_byte_enable,
   input  wire logic [cfgx_pkg::DATA_W-1:0] read_data,
   input  wire logic                        read_data_valid,
   output logic                             cpl_valid,
   output logic                             cpl_from_user,
   output logic [cfgx_pkg::DATA_W-1:0]      cpl_data,
   output logic                             user_reset,
   output logic                             user_clk_tick,
   output logic [cfgx_pkg::LANE_W-1:0]      lane_active
);
   // ------------------------------------------------------------
   // fixed user clock rate and lane mask
   // ------------------------------------------------------------
   localparam int UCLK_KHZ = (UCLK_SEL == cfgx_pkg::UCLK_62)  ? cfgx_pkg::UCLK_62_KHZ :
                             (UCLK_SEL == cfgx_pkg::UCLK_125) ? cfgx_pkg::UCLK_125_KHZ :
                                                                cfgx_pkg::UCLK_250_KHZ;
   localparam int TICK_CYC = (cfgx_pkg::CLK_KHZ + UCLK_KHZ - 1) / UCLK_KHZ;
   localparam logic [1:0] TICK_LAST = 2'(TICK_CYC - 1);
   localparam logic [cfgx_pkg::LANE_W-1:0] LANE_MASK =
      (LINK_WIDTH == cfgx_pkg::WIDTH_X1) ? cfgx_pkg::LANES_X1 :
      (LINK_WIDTH == cfgx_pkg::WIDTH_X2) ? cfgx_pkg::LANES_X2 :
      (LINK_WIDTH == cfgx_pkg::WIDTH_X4) ? cfgx_pkg::LANES_X4 : cfgx_pkg::LANES_X8;

   typedef struct packed {
      cfgx_pkg::cfgx_state_e           state;
      logic                            ready;
      logic                            rd_rcv;
      logic                            wr_rcv;
      logic [cfgx_pkg::REG_W-1:0]      reg_num;
      logic [cfgx_pkg::FUNC_W-1:0]     func;
      logic [cfgx_pkg::DATA_W-1:0]     wdata;
      logic [cfgx_pkg::BE_W-1:0]       be;
      logic                            cvalid;
      logic                            cuser;
      logic [cfgx_pkg::DATA_W-1:0]     cdata;
      logic [1:0]                      tick_cnt;
      logic                            tick;
      logic [cfgx_pkg::LANE_W-1:0]     lanes;
   } cfgx_port_s;

   cfgx_port_s st;
   cfgx_port_s next_st;
   logic       user_hit;
   logic       accept;

   cfgx_reset_bridge u_reset (
      .clock      (clock),
      .nrst       (nrst),
      .sys_reset  (sys_reset),
      .user_reset (user_reset)
   );

   // ------------------------------------------------------------
   // request decode
   // ------------------------------------------------------------
   assign user_hit = (legacy_user_en && req_reg_num >= cfgx_pkg::LEGACY_LO
                      && req_reg_num <= cfgx_pkg::LEGACY_HI)
                   || (ext_user_en && req_reg_num >= cfgx_pkg::EXT_LO
                      && req_reg_num <= cfgx_pkg::EXT_HI);
   assign accept = req_valid && st.ready;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      next_st.wr_rcv = 1'b0;
      next_st.cvalid = 1'b0;
      next_st.cuser = 1'b0;
      next_st.tick = (st.tick_cnt == TICK_LAST);
      next_st.tick_cnt = next_st.tick ? 2'h0 : st.tick_cnt + 2'h1;
      next_st.lanes = LANE_MASK;
      unique case (st.state)
         cfgx_pkg::ST_IDLE:
         begin
            if (st.rd_rcv)
            begin
               next_st.cvalid = 1'b1;
               next_st.cdata = cfgx_pkg::DATA_RST;
            end
            next_st.rd_rcv = 1'b0;
            if (accept)
            begin
               next_st.reg_num = req_reg_num;
               next_st.func = req_func_num;
               if (req_is_write)
               begin
                  next_st.wr_rcv = 1'b1;
                  next_st.wdata = req_write_data;
                  next_st.be = req_byte_enable;
               end
               else
               begin
                  next_st.rd_rcv = 1'b1;
                  if (user_hit)
                  begin
                     next_st.state = cfgx_pkg::ST_HOLD;
                  end
               end
            end
         end
         cfgx_pkg::ST_HOLD:
         begin
            if (read_data_valid)
            begin
               next_st.cdata = read_data;
               next_st.cvalid = 1'b1;
               next_st.cuser = 1'b1;
               next_st.rd_rcv = 1'b0;
               next_st.state = cfgx_pkg::ST_IDLE;
            end
         end
      endcase
      next_st.ready = (next_st.state == cfgx_pkg::ST_IDLE);
      if (!nrst || user_reset)
      begin
         next_st = '{state: cfgx_pkg::ST_IDLE, ready: 1'b0, rd_rcv: 1'b0, wr_rcv: 1'b0,
                     reg_num: cfgx_pkg::REG_RST, func: cfgx_pkg::FUNC_RST,
                     wdata: cfgx_pkg::DATA_RST, be: cfgx_pkg::BE_RST, cvalid: 1'b0,
                     cuser: 1'b0, cdata: cfgx_pkg::DATA_RST, tick_cnt: 2'h0,
                     tick: 1'b0, lanes: cfgx_pkg::LANE_RST};
      end
   end

   always_ff @(posedge clock)
   begin
      st <= next_st;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign req_ready         = st.ready;
   assign read_received     = st.rd_rcv;
   assign write_received    = st.wr_rcv;
   assign register_number   = st.reg_num;
   assign function_number   = st.func;
   assign write_data        = st.wdata;
   assign write_byte_enable = st.be;
   assign cpl_valid         = st.cvalid;
   assign cpl_from_user     = st.cuser;
   assign cpl_data          = st.cdata;
   assign user_clk_tick     = st.tick;
   assign lane_active       = st.lanes;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst || user_reset);

   a_single_read_pulse: assert property (
      accept && !req_is_write && !user_hit |=> read_received ##1 cpl_valid && !cpl_from_user)
      else $error("plain read not a single-cycle indication");
   a_hold_entry: assert property (
      accept && !req_is_write && user_hit |=> read_received && !req_ready)
      else $error("user read not held");
   a_hold_until_valid: assert property (
      read_received && !req_ready && !read_data_valid |=> read_received && !cpl_valid)
      else $error("held read dropped without user data");
   a_write_pulse: assert property (
      accept && req_is_write |=> write_received && !read_received ##1 !cpl_valid)
      else $error("write indication missing");
   a_fields_match: assert property (
      accept |=> register_number == $past(req_reg_num) && function_number == $past(req_func_num))
      else $error("register or function number wrong");
   a_fields_stable: assert property (
      read_received && !req_ready |=> $stable(register_number) && $stable(function_number))
      else $error("fields changed during held read");
   a_write_fields: assert property (
      accept && req_is_write |=> write_data == $past(req_write_data)
         && write_byte_enable == $past(req_byte_enable))
      else $error("write data or byte enables wrong");
   a_capture_data: assert property (
      read_received && !req_ready && read_data_valid |=> cpl_valid && cpl_from_user
         && cpl_data == $past(read_data) && !read_received && req_ready)
      else $error("user read data not captured");
   a_lane_mask: assert property (
      $past(nrst) && !$past(user_reset) |-> lane_active == LANE_MASK)
      else $error("lane mask wrong");
   a_tick_period: assert property (user_clk_tick |-> ##TICK_CYC user_clk_tick)
      else $error("user clock tick period wrong");

   c_plain_read: cover property (accept && !req_is_write && !user_hit);
   c_held_read: cover property (read_received && !req_ready ##3 read_data_valid);
   c_write: cover property (accept && req_is_write ##1 accept && req_is_write);
   c_ext_window: cover property (accept && !req_is_write && user_hit && req_reg_num[8]);
endmodule

// [sim/cfgx_user_model.sv]
/*
 User-logic model that owns the extra configuration registers and answers
 held reads after a chosen number of cycles.
 Assumes it shares the port's clock and changes its outputs at falling edges.
*/
`timescale 1ns/1ns
module cfgx_user_model (
   input  wire logic                        clock,
   input  wire logic                        nrst,
   input  wire logic                        read_received,
   input  wire logic [31:0]                 delay,
   input  wire logic [cfgx_pkg::DATA_W-1:0] answer,
   output logic [cfgx_pkg::DATA_W-1:0]      read_data,
   output logic                             read_data_valid
);
   int   cnt;
   logic done;

   initial
   begin
      cnt = 0;
      done = 1'b0;
      read_data = 32'h0000_0000;
      read_data_valid = 1'b0;
   end

   // ------------------------------------------------------------
   // answer once per indication, data and valid together
   // ------------------------------------------------------------
   always @(negedge clock)
   begin
      if (!nrst || !read_received)
      begin
         cnt <= 0;
         done <= 1'b0;
         read_data_valid <= 1'b0;
         read_data <= ~read_data;
      end
      else if (!done && cnt == delay)
      begin
         read_data_valid <= 1'b1;
         read_data <= answer;
         done <= 1'b1;
         cnt <= cnt + 1;
      end
      else
      begin
         read_data_valid <= 1'b0;
         // stale data must never look valid
         read_data <= ~read_data;
         cnt <= cnt + 1;
      end
   end
endmodule

// [sim/testbench.sv]
/*
 Self-checking bench for the configuration extension port.
 Assumes the user-logic model from cfgx_user_model and a 100 MHz clock.
*/
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value %s expected %h seen %h", n, e, g); end end
module testbench;
   logic clock = 1'b0, nrst = 1'b0, sys_reset = 1'b0, legacy_user_en = 1'b0;
   logic ext_user_en = 1'b0, req_valid = 1'b0, req_is_write = 1'b0;
   logic [9:0]  req_reg_num = 10'h000;
   logic [7:0]  req_func_num = 8'h00;
   logic [31:0] req_write_data = 32'h0000_0000, read_data, cpl_data, write_data;
   logic [3:0]  req_byte_enable = 4'h0, write_byte_enable;
   logic [9:0]  register_number;
   logic [7:0]  function_number, lane_active, x2_lanes;
   logic req_ready, read_received, write_received, read_data_valid, cpl_valid;
   logic cpl_from_user, user_reset, user_clk_tick, x2_tick;
   int   m_delay = 0, n_mismatch = 0, compares = 0;
   logic [31:0] m_answer = 32'h0000_0000;

   always #5 clock = ~clock;

   cfgx_port #(.UCLK_SEL(cfgx_pkg::UCLK_125), .LINK_WIDTH(cfgx_pkg::WIDTH_X8)) u_dut (
      .clock(clock), .nrst(nrst), .sys_reset(sys_reset), .legacy_user_en(legacy_user_en),
      .ext_user_en(ext_user_en), .req_valid(req_valid), .req_is_write(req_is_write),
      .req_reg_num(req_reg_num), .req_func_num(req_func_num),
      .req_write_data(req_write_data), .req_byte_enable(req_byte_enable),
      .req_ready(req_ready), .read_received(read_received),
      .write_received(write_received), .register_number(register_number),
      .function_number(function_number), .write_data(write_data),
      .write_byte_enable(write_byte_enable), .read_data(read_data),
      .read_data_valid(read_data_valid), .cpl_valid(cpl_valid),
      .cpl_from_user(cpl_from_user), .cpl_data(cpl_data), .user_reset(user_reset),
      .user_clk_tick(user_clk_tick), .lane_active(lane_active));

   cfgx_user_model u_user (
      .clock(clock), .nrst(nrst), .read_received(read_received), .delay(m_delay),
      .answer(m_answer), .read_data(read_data), .read_data_valid(read_data_valid));

   // second build: slow user clock, two lanes, link side idle
   cfgx_port #(.UCLK_SEL(cfgx_pkg::UCLK_62), .LINK_WIDTH(cfgx_pkg::WIDTH_X2)) u_dut_x2 (
      .clock(clock), .nrst(nrst), .sys_reset(sys_reset), .legacy_user_en(1'b0),
      .ext_user_en(1'b0), .req_valid(1'b0), .req_is_write(1'b0), .req_reg_num(10'h000),
      .req_func_num(8'h00), .req_write_data(32'h0000_0000), .req_byte_enable(4'h0),
      .req_ready(), .read_received(), .write_received(), .register_number(),
      .function_number(), .write_data(), .write_byte_enable(), .read_data(32'h0000_0000),
      .read_data_valid(1'b0), .cpl_valid(), .cpl_from_user(), .cpl_data(), .user_reset(),
      .user_clk_tick(x2_tick), .lane_active(x2_lanes));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic wait_ready();
      int i;
      for (i = 0; i < 20 && req_ready !== 1'b1; i++)
         @(negedge clock);
      `CHK("req_ready", 1'b1, req_ready)
   endtask

   // called at a falling edge; returns at the falling edge after the accepting edge, while the indication is high
   task automatic send(input logic w, input logic [9:0] r, input logic [7:0] f,
                       input logic [31:0] d, input logic [3:0] be);
      req_valid = 1'b1;
      req_is_write = w;
      req_reg_num = r;
      req_func_num = f;
      req_write_data = d;
      req_byte_enable = be;
      wait_ready();
      @(negedge clock);
      req_valid = 1'b0;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset_state();
      logic t;
      wait_ready();
      `CHK("user_reset", 1'b0, user_reset)
      `CHK("lane_active", cfgx_pkg::LANES_X8, lane_active)
      `CHK("user_clk_tick", 1'b1, user_clk_tick)
      `CHK("x2_lanes", cfgx_pkg::LANES_X2, x2_lanes)
      t = x2_tick;
      @(negedge clock);
      `CHK("x2_tick toggles", 1'b1, x2_tick ^ t)
   endtask

   task automatic t_write();
      send(1'b1, 10'h2a5, 8'h3c, 32'ha5c3_1e07, 4'h5);
      `CHK("write_received", 1'b1, write_received)
      `CHK("register_number", 10'h2a5, register_number)
      `CHK("function_number", 8'h3c, function_number)
      `CHK("write_data", 32'ha5c3_1e07, write_data)
      `CHK("write_byte_enable", 4'h5, write_byte_enable)
      `CHK("read_received", 1'b0, read_received)
      @(negedge clock);
      `CHK("write_received", 1'b0, write_received)
   endtask

   task automatic t_read_plain(input logic [9:0] r, input logic leg, input logic ext);
      legacy_user_en = leg;
      ext_user_en = ext;
      m_delay = 0;
      m_answer = 32'hdead_0001;
      send(1'b0, r, 8'h01, 32'h0000_0000, 4'h0);
      `CHK("read_received", 1'b1, read_received)
      `CHK("register_number", r, register_number)
      `CHK("function_number", 8'h01, function_number)
      @(negedge clock);
      `CHK("read_received", 1'b0, read_received)
      `CHK("cpl_valid", 1'b1, cpl_valid)
      `CHK("cpl_from_user", 1'b0, cpl_from_user)
      `CHK("cpl_data", 32'h0000_0000, cpl_data)
   endtask

   task automatic t_read_user(input logic [9:0] r, input logic leg, input logic ext,
                              input int dly, input logic [31:0] d);
      int i;
      legacy_user_en = leg;
      ext_user_en = ext;
      m_delay = dly;
      m_answer = d;
      send(1'b0, r, 8'h07, 32'h0000_0000, 4'h0);
      `CHK("req_ready", 1'b0, req_ready)
      for (i = 0; i < dly; i++)
      begin
         @(negedge clock);
         `CHK("read_received", 1'b1, read_received)
         `CHK("register_number", r, register_number)
      end
      @(negedge clock);
      `CHK("read_received", 1'b0, read_received)
      `CHK("cpl_valid", 1'b1, cpl_valid)
      `CHK("cpl_from_user", 1'b1, cpl_from_user)
      `CHK("cpl_data", d, cpl_data)
      @(negedge clock);
      `CHK("cpl_valid", 1'b0, cpl_valid)
      `CHK("read_received", 1'b0, read_received)
   endtask

   task automatic t_sys_reset();
      int i;
      #2 sys_reset = 1'b1;
      #1 `CHK("user_reset", 1'b1, user_reset)
      @(negedge clock);
      `CHK("req_ready", 1'b0, req_ready)
      sys_reset = 1'b0;
      for (i = 0; i < 2; i++)
      begin
         @(negedge clock);
         `CHK("user_reset", 1'b1, user_reset)
      end
      @(negedge clock);
      `CHK("user_reset", 1'b0, user_reset)
      t_reset_state();
   endtask

   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial
   begin
      repeat (4) @(negedge clock);
      nrst = 1'b1;
      t_reset_state();
      t_write();
      t_read_plain(10'h010, 1'b0, 1'b0);
      t_read_plain(10'h100, 1'b0, 1'b0);
      t_read_plain(10'h00f, 1'b1, 1'b1);
      t_read_plain(10'h020, 1'b1, 1'b1);
      t_read_plain(10'h0ff, 1'b1, 1'b1);
      t_read_plain(10'h100, 1'b1, 1'b0);
      t_read_user(10'h010, 1'b1, 1'b0, 0, 32'h1234_5678);
      t_read_user(10'h01f, 1'b1, 1'b1, 3, 32'h8765_4321);
      t_read_user(10'h100, 1'b0, 1'b1, 1, 32'hcafe_0100);
      t_read_user(10'h3ff, 1'b1, 1'b1, 2, 32'h0bad_f00d);
      t_write();
      t_sys_reset();
      t_write();
      end_sim();
   end

   initial
   begin
      #20000;
      n_mismatch++;
      end_sim();
   end
endmodule
